// *** rtl/emg_gate.sv ***
// External address match gate on the receive path.
`timescale 1ns/1ps
module emg_gate (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ext_compare_busy,
   input  wire logic ext_dest_match,
   input  wire logic ext_src_match,
   input  wire logic rx_start_delim,
   input  wire logic rx_first_header,
   input  wire logic rx_byte_valid,
   input  wire logic rx_end_delim,
   input  wire logic int_match,
   input  wire logic station_mgmt_frame,
   input  wire logic small_burst_select,
   input  wire logic src_addr_transparency,
   input  wire logic own_address_flag,
   output logic      copy_hold,
   output logic      indicate_channel_two,
   output logic      frame_copy,
   output logic      frame_discard,
   output logic      fifo_overrun,
   output logic      ext_dest_result,
   output logic      ext_src_result,
   output logic      own_frame
);
   import emg_pkg::*;

   logic [2:0]       pins_s;
   logic             busy_s;
   logic             dest_s;
   logic             src_s;
   logic [POS_W-1:0] pos_q;
   logic [EDC_W-1:0] edc_q;
   logic             header_seen_q;
   logic             ed_seen_q;
   logic             int_q;
   logic             smt_q;
   logic             pending_ch2_q;
   logic             decided_q;
   emg_state_e       state_q;
   emg_state_e       state_d;
   logic             t5_expired;
   logic             overrun_hit;
   logic             t4_passed;
   logic             frame_end_ok;
   logic             drop_overrun;
   logic             drop_late;
   logic             end_noext;
   logic             end_done;
   logic             copy_vote;

   // Boundary of the first full burst, in bytes after the header byte.
   function automatic logic [POS_W-1:0] burst_boundary(input logic small_sel);
      burst_boundary = small_sel ? T4_SMALL_POS : T4_SMALL_POS + T4_LARGE_EXTRA;
   endfunction

   emg_sync #(
      .W (3)
   ) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .pin_in   ({ext_compare_busy, ext_dest_match, ext_src_match}),
      .sync_out (pins_s)
   );

   assign busy_s = pins_s[2];
   assign dest_s = pins_s[1];
   assign src_s  = pins_s[0];

   // Byte position since the first header byte, cleared per frame.
   emg_counter #(
      .W (POS_W)
   ) u_pos (
      .clk     (clk),
      .resetn  (resetn),
      .clear   (rx_start_delim || rx_first_header),
      .enable  (header_seen_q && rx_byte_valid),
      .count_q (pos_q)
   );

   // Cycles since the end delimiter.
   emg_counter #(
      .W (EDC_W)
   ) u_edc (
      .clk     (clk),
      .resetn  (resetn),
      .clear   (rx_start_delim || rx_end_delim),
      .enable  (ed_seen_q),
      .count_q (edc_q)
   );

   assign t5_expired  = ed_seen_q && (edc_q >= T5_ED_CYC);
   assign overrun_hit = header_seen_q && (pos_q >= FIFO_BYTES);
   assign t4_passed   = header_seen_q && (pos_q > burst_boundary(small_burst_select));
   assign frame_end_ok = ed_seen_q && !decided_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         header_seen_q <= 1'b0;
         ed_seen_q     <= 1'b0;
         int_q         <= 1'b0;
         smt_q         <= 1'b0;
      end else if (rx_start_delim) begin
         header_seen_q <= 1'b0;
         ed_seen_q     <= 1'b0;
         int_q         <= 1'b0;
         smt_q         <= 1'b0;
      end else begin
         if (rx_first_header) begin
            header_seen_q <= 1'b1;
         end
         if (rx_end_delim) begin
            ed_seen_q <= 1'b1;
            int_q     <= int_match;
            smt_q     <= station_mgmt_frame;
         end
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         EMG_IDLE: begin
            state_d = EMG_IDLE;
         end
         EMG_ARM: begin
            if (header_seen_q && busy_s && (pos_q >= T1_POS) && (pos_q <= T3_POS)) begin
               state_d = EMG_BUSY;
            end else if ((header_seen_q && (pos_q > T3_POS)) || ed_seen_q) begin
               state_d = EMG_NOEXT;
            end
         end
         EMG_BUSY: begin
            if (!busy_s && !t5_expired) begin
               state_d = EMG_SAMPLE;
            end else if (t5_expired || overrun_hit) begin
               state_d = EMG_DONE;
            end
         end
         EMG_SAMPLE: begin
            state_d = EMG_DONE;
         end
         EMG_DONE: begin
            state_d = EMG_DONE;
         end
         EMG_NOEXT: begin
            state_d = EMG_NOEXT;
         end
         default: begin
            state_d = EMG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= EMG_IDLE;
      end else if (rx_start_delim) begin
         state_q <= EMG_ARM;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ext_dest_result <= 1'b0;
         ext_src_result  <= 1'b0;
      end else if (rx_start_delim) begin
         ext_dest_result <= 1'b0;
         ext_src_result  <= 1'b0;
      end else if (state_q == EMG_SAMPLE) begin
         ext_dest_result <= dest_s;
         ext_src_result  <= src_s;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         copy_hold <= 1'b0;
      end else begin
         copy_hold <= (state_d == EMG_BUSY) && !rx_start_delim;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pending_ch2_q <= 1'b0;
      end else if (rx_start_delim) begin
         pending_ch2_q <= 1'b0;
      end else if ((state_q == EMG_BUSY) && busy_s && t4_passed) begin
         pending_ch2_q <= 1'b1;
      end
   end

   // Verdict conditions; the states keep them exclusive except the two drops,
   // where the overrun takes priority.
   assign drop_overrun = !decided_q && (state_q == EMG_BUSY) && busy_s && overrun_hit;
   // not copied, internal match or not
   // A negation first seen at the final edge is already too late, so the
   // strobe level no longer matters here.
   assign drop_late    = frame_end_ok && (state_q == EMG_BUSY) && t5_expired;
   assign end_noext    = frame_end_ok && (state_q == EMG_NOEXT);
   assign end_done     = frame_end_ok && (state_q == EMG_DONE);
   assign copy_vote    = int_q || ext_dest_result;

   // The verdict waits for the end delimiter and for a strobe settled or cut off at T5_ED_CYC; only the overrun
   // drop comes before the end delimiter, so a long compare delays the verdict but never reorders frames.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         decided_q     <= 1'b0;
         frame_copy    <= 1'b0;
         frame_discard <= 1'b0;
         fifo_overrun  <= 1'b0;
      end else begin
         frame_copy    <= 1'b0;
         frame_discard <= 1'b0;
         fifo_overrun  <= 1'b0;
         if (rx_start_delim) begin
            decided_q <= 1'b0;
         end else if (drop_overrun) begin
            decided_q     <= 1'b1;
            frame_discard <= 1'b1;
            fifo_overrun  <= 1'b1;
         end else if (drop_late) begin
            decided_q     <= 1'b1;
            frame_discard <= 1'b1;
         end else if (end_noext) begin
            decided_q     <= 1'b1;
            frame_copy    <= int_q;
            frame_discard <= !int_q;
         end else if (end_done) begin
            decided_q     <= 1'b1;
            frame_copy    <= copy_vote;
            frame_discard <= !copy_vote;
         end
      end
   end

   // channel two overrides sort and management frames
   always_ff @(posedge clk) begin
      if (!resetn) begin
         indicate_channel_two <= 1'b0;
      end else if (rx_start_delim) begin
         indicate_channel_two <= 1'b0;
      end else if (end_done) begin
         indicate_channel_two <= pending_ch2_q && (copy_vote || smt_q);
      end else if (pending_ch2_q && !decided_q) begin
         indicate_channel_two <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         own_frame <= 1'b0;
      end else if (rx_start_delim) begin
         own_frame <= 1'b0;
      end else if (end_noext) begin
         own_frame <= own_address_flag;
      end else if (end_done) begin
         own_frame <= own_address_flag || (src_addr_transparency && ext_src_result);
      end
   end
endmodule

// *** include/emg_pkg.sv ***
// Constants shared by the external address match gate.
package emg_pkg;
   // Position counter width in bits; the counter counts bytes since the first header byte.
   localparam int unsigned     POS_W          = 11;
   localparam int unsigned     EDC_W          = 3;
   // Earliest recognised assertion, bytes after the first header byte.
   localparam logic [10:0]     T1_POS         = 11'h004;
   // Latest recognised first assertion: the byte before the sixth info byte.
   localparam logic [10:0]     T3_POS         = 11'h011;
   // First full burst boundary with small bursts, and the large burst extra.
   localparam logic [10:0]     T4_SMALL_POS   = 11'h010;
   localparam logic [10:0]     T4_LARGE_EXTRA = 11'h010;
   // Last recognised negation, cycles after the end delimiter.
   localparam logic [2:0]      T5_ED_CYC      = 3'h2;
   // Indicate data FIFO capacity in bytes.
   localparam logic [10:0]     FIFO_BYTES     = 11'h400;
   // Synchroniser depth on the three match pins.
   localparam int unsigned     SYNC_STAGES    = 2;
   localparam logic [2:0]      PIN_RESET      = 3'h0;

   typedef enum logic [2:0] {
      EMG_IDLE   = 3'b000,
      EMG_ARM    = 3'b001,
      EMG_BUSY   = 3'b011,
      EMG_SAMPLE = 3'b010,
      EMG_DONE   = 3'b110,
      EMG_NOEXT  = 3'b100
   } emg_state_e;
endpackage

// *** rtl/emg_sync.sv ***
// Two flip-flop synchroniser for the external match pins.
`timescale 1ns/1ps
module emg_sync #(
   parameter int unsigned W = 3
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   import emg_pkg::*;

   logic [W-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** rtl/emg_counter.sv ***
// Saturating up counter with synchronous clear.
`timescale 1ns/1ps
module emg_counter #(
   parameter int unsigned W = 11
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         clear,
   input  wire logic         enable,
   output logic      [W-1:0] count_q
);
   import emg_pkg::*;

   // Saturation keeps long frames from wrapping back into the early windows.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         count_q <= '0;
      end else if (clear) begin
         count_q <= '0;
      end else if (enable && (count_q != {W{1'b1}})) begin
         count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// *** tb/emg_gate_sva.sv ***
// Assertion checker watching the external address match gate ports.
`timescale 1ns/1ps
module emg_gate_sva (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ext_compare_busy,
   input wire logic ext_dest_match,
   input wire logic ext_src_match,
   input wire logic rx_start_delim,
   input wire logic rx_first_header,
   input wire logic rx_byte_valid,
   input wire logic rx_end_delim,
   input wire logic int_match,
   input wire logic station_mgmt_frame,
   input wire logic small_burst_select,
   input wire logic src_addr_transparency,
   input wire logic own_address_flag,
   input wire logic copy_hold,
   input wire logic indicate_channel_two,
   input wire logic frame_copy,
   input wire logic frame_discard,
   input wire logic fifo_overrun,
   input wire logic ext_dest_result,
   input wire logic ext_src_result,
   input wire logic own_frame
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!resetn);
   // Pins pass two synchroniser stages, so the cause lies two to four edges back.
   sequence s_pin_seen;
      $past(ext_compare_busy, 2) || $past(ext_compare_busy, 3) || $past(ext_compare_busy, 4);
   endsequence
   sequence s_held_past_end;
      rx_end_delim && copy_hold && ext_compare_busy && $past(ext_compare_busy) &&
         $past(ext_compare_busy, 2) ##1 ext_compare_busy [*3];
   endsequence
   property p_clear_at_start;
      rx_start_delim |=> !copy_hold && !ext_dest_result && !ext_src_result;
   endproperty
   property p_hold_cause;
      $rose(copy_hold) |-> s_pin_seen;
   endproperty
   property p_no_early_hold;
      rx_first_header |-> ##1 !copy_hold [*4];
   endproperty
   property p_ch2_pending;
      $rose(indicate_channel_two) |-> copy_hold || $past(copy_hold);
   endproperty
   property p_copy_cause;
      frame_copy |-> int_match || ext_dest_result;
   endproperty
   property p_no_copy_in_hold;
      copy_hold |-> !frame_copy;
   endproperty
   property p_own;
      frame_copy |-> own_frame == (own_address_flag | (src_addr_transparency & ext_src_result));
   endproperty
   property p_overrun;
      fifo_overrun |-> frame_discard;
   endproperty
   property p_late_drop;
      s_held_past_end |-> ##1 !frame_copy [*8];
   endproperty
   a_clear_at_start: assert property (p_clear_at_start) else $error("state left over at delimiter");
   a_hold_cause: assert property (p_hold_cause) else $error("hold without strobe");
   a_no_early_hold: assert property (p_no_early_hold) else $error("strobe seen too early");
   a_ch2_pending: assert property (p_ch2_pending) else $error("channel two without pending");
   a_copy_cause: assert property (p_copy_cause) else $error("copy without any match");
   a_no_copy_in_hold: assert property (p_no_copy_in_hold) else $error("copy while holding");
   a_own: assert property (p_own) else $error("own frame flag wrong");
   a_overrun: assert property (p_overrun) else $error("overrun without discard");
   a_late_drop: assert property (p_late_drop) else $error("copy after late negation");
endmodule

bind emg_gate emg_gate_sva u_sva (.clk, .resetn, .ext_compare_busy, .ext_dest_match,
   .ext_src_match, .rx_start_delim, .rx_first_header, .rx_byte_valid, .rx_end_delim,
   .int_match, .station_mgmt_frame, .small_burst_select, .src_addr_transparency,
   .own_address_flag, .copy_hold, .indicate_channel_two, .frame_copy, .frame_discard,
   .fifo_overrun, .ext_dest_result, .ext_src_result, .own_frame);

// *** tb/emg_matcher.sv ***
// Behavioural external address matcher driving the three match pins.
`timescale 1ns/1ps
module emg_matcher (
   input  wire logic clk,
   input  wire logic rx_start_delim,
   input  wire logic enable,
   input  var  int   on_cyc,
   input  var  int   off_cyc,
   input  wire logic dest_hit,
   input  wire logic src_hit,
   output logic      ext_compare_busy,
   output logic      ext_dest_match,
   output logic      ext_src_match
);
   int   cnt_q = 0;
   logic tog_q = 1'b0;
   logic valid;
   always @(posedge clk) begin
      cnt_q <= rx_start_delim ? 1 : cnt_q + 1;
   end
   always @(negedge clk) begin
      tog_q            <= ~tog_q;
      ext_compare_busy <= enable && cnt_q >= on_cyc && cnt_q < off_cyc;
   end
   // both results in one window; outside it the lines wander so stale values never pass.
   assign valid         = enable && cnt_q >= on_cyc && cnt_q < off_cyc + 4;
   assign ext_dest_match = valid ? dest_hit : tog_q;
   assign ext_src_match  = valid ? src_hit : ~tog_q;
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the external address match gate.
`timescale 1ns/1ps
module tb;
   logic clk, resetn, ext_compare_busy, ext_dest_match, ext_src_match, rx_start_delim;
   logic rx_first_header, rx_byte_valid, rx_end_delim, int_match, station_mgmt_frame;
   logic small_burst_select, src_addr_transparency, own_address_flag, copy_hold;
   logic indicate_channel_two, frame_copy, frame_discard, fifo_overrun, ext_dest_result;
   logic ext_src_result, own_frame, m_en, m_dest, m_src, cnt_clr;
   int   m_on, m_off, n_copy, n_disc, n_ovr, n_hold;
   int   num_errors = 0;
   int   num_checks = 0;

   emg_gate dut (.clk, .resetn, .ext_compare_busy, .ext_dest_match, .ext_src_match,
      .rx_start_delim, .rx_first_header, .rx_byte_valid, .rx_end_delim, .int_match,
      .station_mgmt_frame, .small_burst_select, .src_addr_transparency, .own_address_flag,
      .copy_hold, .indicate_channel_two, .frame_copy, .frame_discard, .fifo_overrun,
      .ext_dest_result, .ext_src_result, .own_frame);
   emg_matcher u_match (.clk, .rx_start_delim, .enable(m_en), .on_cyc(m_on), .off_cyc(m_off),
      .dest_hit(m_dest), .src_hit(m_src), .ext_compare_busy, .ext_dest_match, .ext_src_match);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (cnt_clr) begin
         n_copy <= 0;
         n_disc <= 0;
         n_ovr  <= 0;
         n_hold <= 0;
      end else begin
         n_copy <= n_copy + frame_copy;
         n_disc <= n_disc + frame_discard;
         n_ovr  <= n_ovr + fifo_overrun;
         n_hold <= n_hold + copy_hold;
      end
   end

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // One frame; the strobe spans matcher cycles on to off-1, negative on means no matcher.
   task automatic run(input int on, input int off, input logic d, input logic s,
                      input logic im, input int len);
      int i;
      @(negedge clk);
      {m_en, m_on, m_off, m_dest, m_src, int_match} = {on >= 0, on, off, d, s, im};
      cnt_clr        = 1'b1;
      rx_start_delim = 1'b1;
      @(negedge clk);
      cnt_clr         = 1'b0;
      rx_start_delim  = 1'b0;
      rx_first_header = 1'b1;
      for (i = 0; i < len; i++) begin
         @(negedge clk);
         rx_first_header = 1'b0;
         rx_byte_valid   = 1'b1;
      end
      @(negedge clk);
      rx_byte_valid = 1'b0;
      rx_end_delim  = 1'b1;
      @(negedge clk);
      rx_end_delim = 1'b0;
      i = 0;
      while (n_copy + n_disc == 0 && i < 100) begin
         @(negedge clk);
         i++;
      end
      repeat (3) @(negedge clk);
      check(n_copy + n_disc == 1, "one verdict per frame");
   endtask

   task automatic t_no_compare;
      own_address_flag = 1'b1;
      run(-1, 0, 0, 0, 1, 20);
      check(n_copy == 1, "internal match copied");
      check(own_frame === 1'b1, "own flag passed on");
      own_address_flag = 1'b0;
      run(-1, 0, 0, 0, 0, 20);
      check(n_disc == 1 && n_hold == 0, "no match dropped");
      $display("test no_compare done");
   endtask

   task automatic t_ext_match;
      src_addr_transparency = 1'b1;
      run(6, 12, 1, 1, 0, 20);
      check(n_copy == 1 && n_hold > 0, "held then copied");
      check(ext_dest_result === 1'b1 && ext_src_result === 1'b1, "results");
      check(own_frame === 1'b1, "own frame");
      run(6, 7, 0, 0, 0, 20);
      check(n_disc == 1 && n_hold > 0, "short strobe seen");
      check(ext_dest_result === 1'b0 && own_frame === 1'b0, "no match result");
      src_addr_transparency = 1'b0;
      $display("test ext_match done");
   endtask

   task automatic t_late;
      run(30, 36, 1, 0, 0, 40);
      check(n_disc == 1 && n_hold == 0, "late strobe ignored");
      $display("test late done");
   endtask

   task automatic t_channel_two;
      small_burst_select = 1'b1;
      run(1, 26, 1, 0, 0, 40);
      check(n_copy == 1 && indicate_channel_two === 1'b1, "small burst channel two");
      small_burst_select = 1'b0;
      run(1, 26, 1, 0, 0, 40);
      check(n_copy == 1 && indicate_channel_two === 1'b0, "large burst later");
      $display("test channel_two done");
   endtask

   task automatic t_late_end;
      run(6, 60, 1, 0, 1, 30);
      check(n_disc == 1 && n_copy == 0, "held past end dropped");
      run(6, 3000, 1, 0, 1, 1100);
      check(n_ovr == 1 && n_disc == 1, "overrun drop");
      $display("test late_end done");
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      {resetn, rx_start_delim, rx_first_header, rx_byte_valid, rx_end_delim} = '0;
      {int_match, station_mgmt_frame, src_addr_transparency, own_address_flag} = '0;
      {small_burst_select, m_en, m_dest, m_src} = '0;
      {m_on, m_off} = '0;
      cnt_clr = 1'b0;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      t_no_compare();
      t_ext_match();
      t_late();
      t_channel_two();
      t_late_end();
      wrap_up();
   end

   // Tests need about 1450 cycles; the limit leaves wide margin.
   initial begin
      #500000;
      num_errors++;
      wrap_up();
   end
endmodule
